/* File: core/mcatx_top.sv */
// Purpose: Multichannel audio serial transmitter (TDM, I2S, left-justified), bus slave
// Assumes: Bit clock and frame sync come from the host and are sampled by ref_clk_i
// Notes:   Bit clock must be slower than ref_clk_i / 4 for clean edge detection
// Operation
// - TDM frame starts at frame sync rise, slot 0
// - TDM slots follow in ascending order gaplessly
// - TDM bits change on rise, except early MSB
// - Frame sync pulse one or more cycles wide
// - I2S left MSB one fall after sync fall
// - I2S right MSB one fall after sync rise
// - I2S sync and bits change on falling edge
// - LJ left MSB right after sync rise
// - LJ right MSB right after sync fall
// - LJ later bits and sync on falling edge
// - Up to 64 slot positions per frame
// - Unused slots tristated when enabled, else driven
// - Bus holder keeps last level when undriven
// - General purpose pin as second data lane
// - Format field selects TDM, I2S, LJ
// - Word length 16/20/24/32 bits, MSB first
// - Slot start offset of 0 to 31 cycles
// - Invert bits for frame sync and bit clock

`timescale 1ns/1ps

module mcatx_top
   import mcatx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // Audio bus pins
   input wire logic bit_clock_i,
   input wire logic frame_sync_i,
   output mcatx_lane_t data_lane_o,
   output mcatx_lane_t general_purpose_pin_o,
   // Channel words from the converter side
   input wire mcatx_words_t ch_words_i,
   output logic frame_start_o
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] format_r, format_nxt;
   logic [OFFS_W-1:0] offset_r, offset_nxt;
   logic [NUM_CH-1:0][SLOT_W-1:0] slot_r, slot_nxt;
   logic [DATA_W-1:0] ch_en_r, ch_en_nxt;
   logic [2:0] bus_ctrl_r, bus_ctrl_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;

   // Serial engine state
   mcatx_state_t state_r, state_nxt;
   logic [OFFS_W-1:0] delay_r, delay_nxt;
   logic [SCNT_W-1:0] slot_cnt_r, slot_cnt_nxt;
   logic [SCNT_W-1:0] limit_r, limit_nxt;
   logic [SLOT_W-1:0] base_r, base_nxt;
   logic [5:0] bit_cnt_r, bit_cnt_nxt;
   logic right_r, right_nxt;
   mcatx_words_t words_r, words_nxt;
   mcatx_lane_t lane0_r, lane0_nxt, lane1_r, lane1_nxt;
   logic start_r, start_nxt;

   // Pin synchronisers and edge history
   logic bclk_s1_r, bclk_s2_r, bclk_d_r;
   logic fs_s1_r, fs_s2_r, fs_prev_r, fs_prev_nxt;

   // Decoded configuration
   mcatx_fmt_t fmt;
   logic [5:0] wlen;
   logic fs_inv, bclk_inv, tri_en, hold_en, lane2_en;
   logic bclk_now, bclk_was, rise, fall, launch, capture, fs_now;

   // ----------------------------------------------------------------
   // Configuration decode
   // ----------------------------------------------------------------
   // Format and word length selection
   always_comb begin
      fmt = mcatx_fmt_t'(format_r[FMT_SEL_LSB +: 2]);
      case (format_r[FMT_WLEN_LSB +: 2])
         2'b00: wlen = WLEN_16;
         2'b01: wlen = WLEN_20;
         2'b10: wlen = WLEN_24;
         default: wlen = WLEN_32;
      endcase
   end

   // Control bits
   assign fs_inv = format_r[FMT_FS_INV_BIT];
   assign bclk_inv = format_r[FMT_BCLK_INV_BIT];
   assign tri_en = bus_ctrl_r[CTL_TRISTATE_BIT];
   assign hold_en = bus_ctrl_r[CTL_HOLDER_BIT];
   assign lane2_en = bus_ctrl_r[CTL_LANE2_BIT];

   // ----------------------------------------------------------------
   // Bit clock edges and frame sync sampling
   // ----------------------------------------------------------------
   // Edges found on the second stage against its delayed copy only
   always_comb begin
      bclk_now = bclk_s2_r ^ bclk_inv;
      bclk_was = bclk_d_r ^ bclk_inv;
      rise = bclk_now & ~bclk_was;
      fall = ~bclk_now & bclk_was;
      // TDM launches on rise, I2S and LJ on fall
      launch = (fmt == MCATX_FMT_TDM) ? rise : fall;
      capture = (fmt == MCATX_FMT_TDM) ? fall : rise;
      fs_now = fs_s2_r ^ fs_inv;
   end

   // ----------------------------------------------------------------
   // Lane update helper
   // ----------------------------------------------------------------
   // Unused slots either float, with optional keeper, or drive low
   function automatic mcatx_lane_t lane_step(input logic hit, input logic b, input mcatx_lane_t cur,
                                             input logic tri_on, input logic hold_on);
      mcatx_lane_t l;
      l = cur;
      if (hit) begin
         l.dat = b;
         l.oe = 1'b1;
         l.keep = 1'b0;
      end else if (tri_on) begin
         l.oe = 1'b0;
         l.keep = hold_on;
      end else begin
         l.dat = 1'b0;
         l.oe = 1'b1;
         l.keep = 1'b0;
      end
      return l;
   endfunction

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   // Frame detection, slot offset, slot and bit counting
   always_comb begin
      logic do_step;
      logic hit0, hit1, b0, b1;
      logic [SLOT_W-1:0] abs_slot;
      do_step = 1'b0;
      hit0 = 1'b0;
      hit1 = 1'b0;
      b0 = 1'b0;
      b1 = 1'b0;
      abs_slot = '0;
      state_nxt = state_r;
      delay_nxt = delay_r;
      slot_cnt_nxt = slot_cnt_r;
      limit_nxt = limit_r;
      base_nxt = base_r;
      bit_cnt_nxt = bit_cnt_r;
      right_nxt = right_r;
      words_nxt = words_r;
      lane0_nxt = lane0_r;
      lane1_nxt = lane1_r;
      start_nxt = 1'b0;
      fs_prev_nxt = capture ? fs_now : fs_prev_r;
      if (fmt == MCATX_FMT_RSV) begin
         state_nxt = MCATX_ST_IDLE;
      end else if (capture && (fs_now != fs_prev_r)) begin
         // A frame sync rise opens a TDM frame; any level change opens an I2S or LJ half frame
         if (fmt == MCATX_FMT_TDM) begin
            right_nxt = 1'b0;
            limit_nxt = SLOTS_TDM;
            do_step = fs_now;
         end else if (fmt == MCATX_FMT_I2S) begin
            right_nxt = fs_now;
            limit_nxt = SLOTS_HALF;
         end else begin
            right_nxt = ~fs_now;
            limit_nxt = SLOTS_HALF;
            do_step = 1'b1;
         end
         if ((fmt != MCATX_FMT_TDM) || fs_now) begin
            base_nxt = right_nxt ? RIGHT_BASE : '0;
            slot_cnt_nxt = '0;
            bit_cnt_nxt = '0;
            delay_nxt = offset_r;
            state_nxt = MCATX_ST_OFFSET;
            if (!right_nxt) begin
               words_nxt = ch_words_i;
               start_nxt = 1'b1;
            end
         end
      end else if (launch && (state_r != MCATX_ST_IDLE)) begin
         do_step = 1'b1;
      end
      if (do_step && (state_nxt != MCATX_ST_IDLE)) begin
         if (delay_nxt != '0) begin
            // Offset cycles count before slot 0 begins
            delay_nxt = delay_nxt - 1'b1;
            lane0_nxt = lane_step(1'b0, 1'b0, lane0_r, tri_en, hold_en);
            lane1_nxt = lane_step(1'b0, 1'b0, lane1_r, tri_en, hold_en);
         end else if (slot_cnt_nxt < limit_nxt) begin
            state_nxt = MCATX_ST_SHIFT;
            abs_slot = base_nxt + slot_cnt_nxt[SLOT_W-1:0];
            for (int ch = 0; ch < NUM_CH; ch++) begin
               if (ch_en_r[ch] && (slot_r[ch] == abs_slot)) begin
                  // MSB first from the top of each word
                  if (lane2_en && (ch >= NUM_CH / 2)) begin
                     hit1 = 1'b1;
                     b1 = words_nxt.word[ch][WORD_W - 1 - int'(bit_cnt_nxt)];
                  end else begin
                     hit0 = 1'b1;
                     b0 = words_nxt.word[ch][WORD_W - 1 - int'(bit_cnt_nxt)];
                  end
               end
            end
            lane0_nxt = lane_step(hit0, b0, lane0_r, tri_en, hold_en);
            lane1_nxt = lane_step(hit1, b1, lane1_r, tri_en, hold_en);
            // Slots follow back to back, each exactly one word long
            if (bit_cnt_nxt == wlen - 6'h01) begin
               bit_cnt_nxt = '0;
               slot_cnt_nxt = slot_cnt_nxt + 1'b1;
            end else begin
               bit_cnt_nxt = bit_cnt_nxt + 1'b1;
            end
         end else begin
            state_nxt = MCATX_ST_IDLE;
            lane0_nxt = lane_step(1'b0, 1'b0, lane0_r, tri_en, hold_en);
            lane1_nxt = lane_step(1'b0, 1'b0, lane1_r, tri_en, hold_en);
         end
      end
      if (!lane2_en) begin
         lane1_nxt = '0;
      end
   end

   // Engine registers and pin synchronisers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_r <= MCATX_ST_IDLE;
         delay_r <= '0;
         slot_cnt_r <= '0;
         limit_r <= '0;
         base_r <= '0;
         bit_cnt_r <= '0;
         right_r <= 1'b0;
         words_r <= '0;
         lane0_r <= '0;
         lane1_r <= '0;
         start_r <= 1'b0;
         bclk_s1_r <= 1'b0;
         bclk_s2_r <= 1'b0;
         bclk_d_r <= 1'b0;
         fs_s1_r <= 1'b0;
         fs_s2_r <= 1'b0;
         fs_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         delay_r <= delay_nxt;
         slot_cnt_r <= slot_cnt_nxt;
         limit_r <= limit_nxt;
         base_r <= base_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         right_r <= right_nxt;
         words_r <= words_nxt;
         lane0_r <= lane0_nxt;
         lane1_r <= lane1_nxt;
         start_r <= start_nxt;
         bclk_s1_r <= bit_clock_i;
         bclk_s2_r <= bclk_s1_r;
         bclk_d_r <= bclk_s2_r;
         fs_s1_r <= frame_sync_i;
         fs_s2_r <= fs_s1_r;
         fs_prev_r <= fs_prev_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   // Writes and read data; read data only in the cycle after the strobe
   always_comb begin
      format_nxt = format_r;
      offset_nxt = offset_r;
      slot_nxt = slot_r;
      ch_en_nxt = ch_en_r;
      bus_ctrl_nxt = bus_ctrl_r;
      rdata_nxt = '0;
      if (reg_wr_i) begin
         if (reg_addr_i == ADDR_FORMAT) begin
            format_nxt = reg_wdata_i;
         end else if (reg_addr_i == ADDR_OFFSET) begin
            offset_nxt = reg_wdata_i[OFFS_W-1:0];
         end else if ((reg_addr_i >= ADDR_SLOT_FIRST) && (reg_addr_i <= ADDR_SLOT_LAST)) begin
            slot_nxt[reg_addr_i - ADDR_SLOT_FIRST] = reg_wdata_i[SLOT_W-1:0];
         end else if (reg_addr_i == ADDR_CH_ENABLE) begin
            ch_en_nxt = reg_wdata_i;
         end else if (reg_addr_i == ADDR_BUS_CTRL) begin
            bus_ctrl_nxt = reg_wdata_i[2:0];
         end
      end
      if (reg_rd_i) begin
         if (reg_addr_i == ADDR_FORMAT) begin
            rdata_nxt = {format_r[DATA_W-1:2], 2'b00};
         end else if (reg_addr_i == ADDR_OFFSET) begin
            rdata_nxt = {3'b000, offset_r};
         end else if ((reg_addr_i >= ADDR_SLOT_FIRST) && (reg_addr_i <= ADDR_SLOT_LAST)) begin
            rdata_nxt = {2'b00, slot_r[reg_addr_i - ADDR_SLOT_FIRST]};
         end else if (reg_addr_i == ADDR_CH_ENABLE) begin
            rdata_nxt = ch_en_r;
         end else if (reg_addr_i == ADDR_BUS_CTRL) begin
            rdata_nxt = {5'b00000, bus_ctrl_r};
         end else if (reg_addr_i == ADDR_STATUS) begin
            rdata_nxt = '0;
            rdata_nxt[STAT_ACTIVE_BIT] = (state_r != MCATX_ST_IDLE);
            rdata_nxt[STAT_RIGHT_BIT] = right_r;
            rdata_nxt[SLOT_W-1:0] = base_r + slot_cnt_r[SLOT_W-1:0];
         end
      end
   end

   // Register file flops; channel n defaults to slot n
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         format_r <= RST_FORMAT;
         offset_r <= RST_OFFSET;
         for (int ch = 0; ch < NUM_CH; ch++) begin
            slot_r[ch] <= SLOT_W'(ch);
         end
         ch_en_r <= RST_CH_ENABLE;
         bus_ctrl_r <= RST_BUS_CTRL;
         rdata_r <= '0;
      end else begin
         format_r <= format_nxt;
         offset_r <= offset_nxt;
         slot_r <= slot_nxt;
         ch_en_r <= ch_en_nxt;
         bus_ctrl_r <= bus_ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o = rdata_r;
   assign data_lane_o = lane0_r;
   assign general_purpose_pin_o = lane1_r;
   assign frame_start_o = start_r;

endmodule

/* File: core/mcatx_pkg.sv */
// Purpose: Shared constants and types for the multichannel audio serial transmitter
// Assumes: 8-bit register port, 4-bit register address
// Notes:   Offsets, field positions and reset values are named here only once

package mcatx_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_CH = 8;
   localparam int WORD_W = 32;
   localparam int SLOT_W = 6;
   localparam int OFFS_W = 5;
   localparam int SCNT_W = 7;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_FORMAT = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_SLOT_FIRST = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_SLOT_LAST = 4'h9;
   localparam logic [ADDR_W-1:0] ADDR_CH_ENABLE = 4'hA;
   localparam logic [ADDR_W-1:0] ADDR_BUS_CTRL = 4'hB;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hC;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int FMT_SEL_LSB = 6;
   localparam int FMT_WLEN_LSB = 4;
   localparam int FMT_FS_INV_BIT = 3;
   localparam int FMT_BCLK_INV_BIT = 2;
   localparam int CTL_TRISTATE_BIT = 0;
   localparam int CTL_HOLDER_BIT = 1;
   localparam int CTL_LANE2_BIT = 2;
   localparam int STAT_ACTIVE_BIT = 7;
   localparam int STAT_RIGHT_BIT = 6;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_FORMAT = 8'h30;
   localparam logic [OFFS_W-1:0] RST_OFFSET = 5'h00;
   localparam logic [DATA_W-1:0] RST_CH_ENABLE = 8'h03;
   localparam logic [2:0] RST_BUS_CTRL = 3'h0;

   // ----------------------------------------------------------------
   // Slot geometry and word lengths
   // ----------------------------------------------------------------
   localparam logic [SCNT_W-1:0] SLOTS_TDM = 7'h40;
   localparam logic [SCNT_W-1:0] SLOTS_HALF = 7'h20;
   localparam logic [SLOT_W-1:0] RIGHT_BASE = 6'h20;
   localparam logic [5:0] WLEN_16 = 6'h10;
   localparam logic [5:0] WLEN_20 = 6'h14;
   localparam logic [5:0] WLEN_24 = 6'h18;
   localparam logic [5:0] WLEN_32 = 6'h20;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MCATX_FMT_TDM = 2'b00,
      MCATX_FMT_I2S = 2'b01,
      MCATX_FMT_LJ = 2'b10,
      MCATX_FMT_RSV = 2'b11
   } mcatx_fmt_t;

   typedef enum logic [1:0] {
      MCATX_ST_IDLE = 2'b00,
      MCATX_ST_OFFSET = 2'b01,
      MCATX_ST_SHIFT = 2'b10
   } mcatx_state_t;

   typedef struct packed {
      logic dat;
      logic oe;
      logic keep;
   } mcatx_lane_t;

   typedef struct packed {
      logic [NUM_CH-1:0][WORD_W-1:0] word;
   } mcatx_words_t;

endpackage

/* File: testbench/mcatx_checker.sv */
// Purpose: Port-level assertions for the audio serial transmitter
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bit clock period is several ref_clk cycles in every run

`timescale 1ns/1ps

module mcatx_checker
   import mcatx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [DATA_W-1:0] reg_rdata_o,
   // Audio pins and lanes
   input wire logic bit_clock_i,
   input wire logic frame_sync_i,
   input wire mcatx_lane_t data_lane_o,
   input wire mcatx_lane_t general_purpose_pin_o,
   input wire logic frame_start_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic [3:0] bc_age_r, bc_age_nxt, fs_age_r, fs_age_nxt;
   logic bc_q_r, fs_q_r, lane2_r, lane2_nxt;

   // Ages saturate so an idle link reads as long quiet
   always_comb begin
      bc_age_nxt = (bc_age_r == 4'hF) ? bc_age_r : bc_age_r + 4'h1;
      fs_age_nxt = (fs_age_r == 4'hF) ? fs_age_r : fs_age_r + 4'h1;
      lane2_nxt = lane2_r;
      if (bit_clock_i != bc_q_r) bc_age_nxt = 4'h0;
      if (frame_sync_i != fs_q_r) fs_age_nxt = 4'h0;
      if (reg_wr_i && reg_addr_i == ADDR_BUS_CTRL) lane2_nxt = reg_wdata_i[CTL_LANE2_BIT];
      // Reset leaves the link reading as long quiet
      if (srst_i) begin
         bc_age_nxt = 4'hF;
         fs_age_nxt = 4'hF;
         lane2_nxt = 1'b0;
      end
   end

   // Register the helper values
   always_ff @(posedge ref_clk_i) begin
      bc_q_r <= bit_clock_i;
      fs_q_r <= frame_sync_i;
      bc_age_r <= bc_age_nxt;
      fs_age_r <= fs_age_nxt;
      lane2_r <= lane2_nxt;
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_rd(a);
      $past(reg_rd_i) && $past(reg_addr_i) == a;
   endsequence
   sequence s_held;
      !data_lane_o.oe && data_lane_o.keep ##1 !data_lane_o.oe && data_lane_o.keep;
   endsequence

   property p_fmt_low;
      s_rd(ADDR_FORMAT) |-> reg_rdata_o[1:0] == 2'b00;
   endproperty
   a_fmt_low: assert property (p_fmt_low) else $error("format low bits set");
   property p_offs_w;
      s_rd(ADDR_OFFSET) |-> reg_rdata_o[7:5] == 3'h0;
   endproperty
   a_offs_w: assert property (p_offs_w) else $error("offset wider than 5 bits");
   property p_slot_w;
      $past(reg_rd_i) && $past(reg_addr_i) inside {[ADDR_SLOT_FIRST:ADDR_SLOT_LAST]}
         |-> reg_rdata_o[7:6] == 2'h0;
   endproperty
   a_slot_w: assert property (p_slot_w) else $error("slot wider than 6 bits");
   // Data only moves shortly after a bit clock edge
   property p_quiet;
      $changed(data_lane_o.dat) |-> bc_age_r <= 4'h5;
   endproperty
   a_quiet: assert property (p_quiet) else $error("data moved without bit clock");
   property p_start_cause;
      frame_start_o |-> fs_age_r <= 4'hA;
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("frame start without sync edge");
   property p_start_once;
      frame_start_o |=> !frame_start_o [*4];
   endproperty
   a_start_once: assert property (p_start_once) else $error("frame start repeated");
   property p_gp_off;
      !lane2_r && !$past(lane2_r) |-> general_purpose_pin_o == 3'h0;
   endproperty
   a_gp_off: assert property (p_gp_off) else $error("second lane active while off");
   property p_held;
      s_held |-> $stable(data_lane_o.dat);
   endproperty
   a_held: assert property (p_held) else $error("held level changed");
endmodule

bind mcatx_top mcatx_checker chk_u (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bit_clock_i(bit_clock_i),
   .frame_sync_i(frame_sync_i), .data_lane_o(data_lane_o),
   .general_purpose_pin_o(general_purpose_pin_o), .frame_start_o(frame_start_o)
);

/* File: testbench/mcatx_host.sv */
// Purpose: Behavioural host that clocks frames and captures lanes
// Assumes: Bit clock of 800 ns, still between frames
// Notes:   Lanes are sampled 150 ns after each bit clock rise, after each fall in LJ

`timescale 1ns/1ps

module mcatx_host
   import mcatx_pkg::*;
(
   // Link pins toward the block
   output logic bit_clock_o,
   output logic frame_sync_o,
   // Lanes from the block
   input wire mcatx_lane_t lane_i,
   input wire mcatx_lane_t gp_i
);
   logic bclk = 1'b0;
   logic inv_r = 1'b0;
   logic fs = 1'b0;
   mcatx_lane_t cap_d [0:127];
   mcatx_lane_t cap_g [0:127];

   assign frame_sync_o = fs ^ inv_r;
   assign bit_clock_o = bclk ^ inv_r;

   // Grab both lanes into capture entry j
   task automatic grab(input int j);
      cap_d[j] = lane_i;
      cap_g[j] = gp_i;
   endtask

   // One frame of n+1 bit clocks; k = left half length; inv flips both pins
   task automatic run_frame(input mcatx_fmt_t fmt, input int n, input int k, input logic inv);
      // Start off the ref_clk edge so pin changes never race its sampling
      #10;
      inv_r = inv;
      fs = (fmt == MCATX_FMT_I2S);
      #800;
      for (int i = 0; i <= n; i++) begin
         bclk = 1'b1;
         if (fmt == MCATX_FMT_TDM) fs = (i == 0);
         #150;
         if (fmt != MCATX_FMT_LJ && i > 0) grab(i - 1);
         #250;
         bclk = 1'b0;
         if (fmt == MCATX_FMT_I2S) fs = (i >= k);
         if (fmt == MCATX_FMT_LJ) fs = (i < k);
         #150;
         if (fmt == MCATX_FMT_LJ && i > 0) grab(i - 1);
         #250;
      end
   endtask
endmodule

/* File: testbench/test_mcatx_top.sv */
// Purpose: Self-checking bench for the audio serial transmitter
// Assumes: 10 MHz ref_clk, host model drives the link
// Notes:   Slot streams are rebuilt from captured lane bits

`timescale 1ns/1ps

module test_mcatx_top
   import mcatx_pkg::*;
;
   logic ref_clk_i, srst_i, reg_wr_i, reg_rd_i, bclk, frame_sync, fstart;
   logic [ADDR_W-1:0] reg_addr_i;
   logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
   mcatx_lane_t lane, gp_lane;
   mcatx_words_t words;
   int error_cnt = 0;
   int checked = 0;
   int cyc_cnt = 0;
   int starts = 0;

   mcatx_top dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .bit_clock_i(bclk), .frame_sync_i(frame_sync), .data_lane_o(lane), .general_purpose_pin_o(gp_lane),
      .ch_words_i(words), .frame_start_o(fstart));
   mcatx_host host_u (.bit_clock_o(bclk), .frame_sync_o(frame_sync), .lane_i(lane), .gp_i(gp_lane));

   // Clock and hang guard
   always #50 ref_clk_i = ~ref_clk_i;
   // Frame start pulses seen so far
   always @(posedge ref_clk_i) begin
      if (fstart) starts <= starts + 1;
   end
   always @(posedge ref_clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 10000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("checked %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Strobes last one cycle with an idle cycle after
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = 32'(reg_rdata_o);
   endtask
   // Undriven bits turn to X so a dropped enable cannot match
   task automatic chk_word(input string what, input int base, input int ch, input int wl, input bit gp);
      logic [31:0] got;
      mcatx_lane_t c;
      got = 32'h0;
      for (int j = 0; j < wl; j++) begin
         c = gp ? host_u.cap_g[base + j] : host_u.cap_d[base + j];
         got = {got[30:0], c.oe ? c.dat : 1'bx};
      end
      chk(what, words.word[ch] >> (32 - wl), got);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_regs();
      logic [31:0] d;
      rd(ADDR_FORMAT, d);
      chk("format reset", 32'(RST_FORMAT), d);
      rd(ADDR_OFFSET, d);
      chk("offset reset", 32'(RST_OFFSET), d);
      rd(4'hE, d);
      chk("unmapped read", 32'h0, d);
      wr(ADDR_OFFSET, 8'hFF);
      rd(ADDR_OFFSET, d);
      chk("offset field", 32'h1F, d);
      wr(4'h5, 8'hFF);
      rd(4'h5, d);
      chk("slot field", 32'h3F, d);
      wr(4'h5, 8'h03);
      $display("test regs done");
   endtask

   task automatic test_tdm(input logic [1:0] wcode, input int offs, input logic [7:0] ctrl, input logic inv);
      int wl;
      mcatx_lane_t c;
      int s0;
      wl = (wcode == 2'h3) ? 32 : 16 + 4 * wcode;
      wr(ADDR_FORMAT, {2'b00, wcode, inv, inv, 2'b00});
      wr(ADDR_OFFSET, 8'(offs));
      wr(ADDR_BUS_CTRL, ctrl);
      s0 = starts;
      host_u.run_frame(MCATX_FMT_TDM, 2 * wl + offs + 3, 0, inv);
      chk_word("tdm slot 0", offs, 0, wl, 0);
      chk_word("tdm slot 1", offs + wl, 1, wl, 0);
      chk("frame starts", 32'h1, 32'(starts - s0));
      c = host_u.cap_d[offs + 2 * wl + 1];
      if (ctrl[0]) chk("unused slot", {29'h0, words.word[1][32 - wl], 2'b01}, 32'(c));
      else chk("unused slot", 32'h1, {30'h0, c.dat, c.oe});
      $display("test tdm %0d bits done", wl);
   endtask

   task automatic test_lr(input mcatx_fmt_t fmt);
      int lb;
      lb = (fmt == MCATX_FMT_I2S) ? 1 : 0;
      wr(ADDR_FORMAT, {fmt, 6'h00});
      wr(ADDR_OFFSET, 8'h00);
      wr(4'h3, 8'h20);
      host_u.run_frame(fmt, 38, 20, 1'b0);
      chk_word("left slot 0", lb, 0, 16, 0);
      chk_word("right slot 0", 20 + lb, 1, 16, 0);
      wr(4'h3, 8'h01);
      $display("test left right %0d done", fmt);
   endtask

   task automatic test_lane2();
      mcatx_lane_t c0;
      wr(ADDR_FORMAT, 8'h00);
      wr(ADDR_CH_ENABLE, 8'h10);
      wr(ADDR_SLOT_FIRST + 4'h4, 8'h00);
      wr(ADDR_BUS_CTRL, 8'h04);
      host_u.run_frame(MCATX_FMT_TDM, 20, 0, 1'b0);
      chk_word("second lane", 0, 4, 16, 1);
      wr(ADDR_BUS_CTRL, 8'h00);
      wr(ADDR_FORMAT, 8'hC0);
      #1 c0 = lane;
      host_u.run_frame(MCATX_FMT_TDM, 20, 0, 1'b0);
      chk("reserved format lane", 32'(c0), 32'(lane));
      $display("test lane2 and reserved done");
   endtask

   // Main sequence
   initial begin
      ref_clk_i = 1'b0;
      srst_i = 1'b1;
      reg_addr_i = 4'h0;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      for (int k = 0; k < NUM_CH; k++) words.word[k] = 32'h9E37_79B9 * (k + 1);
      repeat (3) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      test_regs();
      test_tdm(2'h0, 0, 8'h00, 1'b0);
      test_tdm(2'h1, 2, 8'h03, 1'b0);
      test_tdm(2'h2, 0, 8'h03, 1'b1);
      test_tdm(2'h3, 31, 8'h00, 1'b0);
      test_lr(MCATX_FMT_I2S);
      test_lr(MCATX_FMT_LJ);
      test_lane2();
      finish_test();
   end
endmodule
